/* File: hw/vsm_dwell_timer.sv */
// dwell qualifier: output rises after a condition holds unbroken for a time in ms
`timescale 1ns/1ps
`default_nettype none
module vsm_dwell_timer
    import vsm_pkg::*;
(
    // clock and reset
    input  wire logic                pclk,
    input  wire logic                presetn,
    input  wire logic                ce,
    // settings
    input  wire logic [MS_CNT_W-1:0] cycles_per_ms,
    input  wire logic [15:0]         dwell_ms,
    // condition and result
    input  wire logic                cond,
    output logic                     qualified
);

    vsm_dwell_state_type state_reg;
    vsm_dwell_state_type state_next;
    logic [MS_CNT_W-1:0] sub_reg;
    logic [MS_CNT_W-1:0] sub_next;
    logic [15:0]         ms_reg;
    logic [15:0]         ms_next;

    wire                 tick    = (sub_reg == (cycles_per_ms - MS_CNT_W'(1)));
    wire [15:0]          ms_inc  = ms_reg + 16'h0001;

    always_comb begin
        state_next = state_reg;
        sub_next   = '0;
        ms_next    = '0;
        case (state_reg)
            VSM_DW_IDLE: begin
                if (cond) begin
                    state_next = (dwell_ms == 16'h0000) ? VSM_DW_HELD : VSM_DW_COUNT;
                end
            end
            VSM_DW_COUNT: begin
                // restart from zero on any break of the condition
                if (!cond) begin
                    state_next = VSM_DW_IDLE;
                end else if (tick) begin
                    ms_next = ms_inc;
                    if (ms_inc >= dwell_ms) begin
                        state_next = VSM_DW_HELD;
                    end
                end else begin
                    sub_next = sub_reg + MS_CNT_W'(1);
                    ms_next  = ms_reg;
                end
            end
            VSM_DW_HELD: begin
                if (!cond) begin
                    state_next = VSM_DW_IDLE;
                end
            end
            default: begin
                state_next = VSM_DW_IDLE;
            end
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_reg <= VSM_DW_IDLE;
            sub_reg   <= '0;
            ms_reg    <= '0;
        end else if (ce) begin
            state_reg <= state_next;
            sub_reg   <= sub_next;
            ms_reg    <= ms_next;
        end
    end

    assign qualified = (state_reg == VSM_DW_HELD);

    a_dwell_break: assert property (@(posedge pclk) disable iff (!presetn)
        ce && !cond |=> !qualified)
        else $error("dwell qualifier held across a broken condition");

endmodule
`default_nettype wire

/* File: hw/vsm_pin_driver.sv */
// digital output pin: maps a function code and polarity to a closed contact
`timescale 1ns/1ps
`default_nettype none
module vsm_pin_driver
    import vsm_pkg::*;
(
    // clock and reset
    input  wire logic       pclk,
    input  wire logic       presetn,
    input  wire logic       ce,
    // selection and sources
    input  wire logic [5:0] func,
    input  wire logic       reach,
    input  wire logic       coin,
    // pin state, high means closed
    output logic            closed
);

    logic closed_next;

    always_comb begin
        case (func)
            FUNC_REACH_CLOSED: closed_next = reach;
            FUNC_REACH_OPEN:   closed_next = !reach;
            FUNC_COIN_CLOSED:  closed_next = coin;
            FUNC_COIN_OPEN:    closed_next = !coin;
            default:           closed_next = 1'b0;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            closed <= 1'b0;
        end else if (ce) begin
            closed <= closed_next;
        end
    end

endmodule
`default_nettype wire

/* File: hw/vsm_pkg.sv */
// constants, register map and carrier types for the velocity status monitor
package vsm_pkg;

    // clock and time base
    localparam int unsigned CLK_PERIOD_NS = 8;
    localparam int unsigned MS_NS         = 1000000;
    localparam int unsigned CYCLES_PER_MS = MS_NS / CLK_PERIOD_NS;
    localparam int unsigned MS_CNT_W      = 17;

    // register byte addresses
    localparam logic [11:0] ADDR_CTRL       = 12'h000;
    localparam logic [11:0] ADDR_DWELL      = 12'h004;
    localparam logic [11:0] ADDR_REACH_THR  = 12'h008;
    localparam logic [11:0] ADDR_BAND       = 12'h00C;
    localparam logic [11:0] ADDR_PROP_GAIN  = 12'h010;
    localparam logic [11:0] ADDR_INTEG_TIME = 12'h014;
    localparam logic [11:0] ADDR_POS_LIMIT  = 12'h018;
    localparam logic [11:0] ADDR_PIN_FUNC   = 12'h01C;
    localparam logic [11:0] ADDR_STATUS     = 12'h020;
    localparam logic [11:0] ADDR_IRQ_STATUS = 12'h024;
    localparam logic [11:0] ADDR_IRQ_CLEAR  = 12'h028;
    localparam logic [11:0] ADDR_IRQ_ENABLE = 12'h02C;

    // field positions
    localparam int unsigned CTRL_METHOD_LSB = 0;
    localparam int unsigned CTRL_MODE_BIT   = 8;
    localparam int unsigned PIN1_FUNC_LSB   = 8;
    localparam int unsigned IRQ_W           = 3;
    localparam int unsigned IRQ_REACH_BIT   = 0;
    localparam int unsigned IRQ_COIN_BIT    = 1;
    localparam int unsigned IRQ_ALARM_BIT   = 2;
    localparam int unsigned PIN_COUNT       = 2;

    // codes
    localparam logic [1:0] METHOD_POS_TIME   = 2'h1;
    localparam logic [1:0] METHOD_SPEED_ONLY = 2'h2;
    localparam logic       MODE_VELOCITY     = 1'h0;
    localparam logic       MODE_TORQUE       = 1'h1;
    localparam logic [5:0] FUNC_COIN_CLOSED  = 6'h11;
    localparam logic [5:0] FUNC_COIN_OPEN    = 6'h12;
    localparam logic [5:0] FUNC_REACH_CLOSED = 6'h13;
    localparam logic [5:0] FUNC_REACH_OPEN   = 6'h14;

    // limits and reset values, speeds in 0.1 rps
    localparam logic [15:0] DWELL_DEF     = 16'h000A;
    localparam logic [15:0] DWELL_MAX     = 16'h7530;
    localparam logic [9:0]  REACH_DEF     = 10'h064;
    localparam logic [9:0]  REACH_MAX     = 10'h3E8;
    localparam logic [9:0]  BAND_DEF      = 10'h002;
    localparam logic [9:0]  BAND_MIN      = 10'h001;
    localparam logic [9:0]  BAND_MAX      = 10'h3E8;
    localparam logic [14:0] PROP_DEF      = 15'h00B7;
    localparam logic [14:0] INTEG_DEF     = 15'h00BD;
    localparam logic [14:0] GAIN_MAX      = 15'h7530;
    localparam logic [31:0] POS_LIMIT_DEF = 32'h0001_0000;

    typedef struct packed {
        logic [1:0]  method;
        logic        ctrl_mode;
        logic [15:0] dwell_ms;
        logic [9:0]  reach_thr;
        logic [9:0]  band;
        logic [14:0] prop_gain;
        logic [14:0] integ_time;
        logic [31:0] pos_limit;
        logic [5:0]  pin_func0;
        logic [5:0]  pin_func1;
    } vsm_cfg_type;

    localparam vsm_cfg_type CFG_DEF = '{
        method:     METHOD_SPEED_ONLY,
        ctrl_mode:  MODE_VELOCITY,
        dwell_ms:   DWELL_DEF,
        reach_thr:  REACH_DEF,
        band:       BAND_DEF,
        prop_gain:  PROP_DEF,
        integ_time: INTEG_DEF,
        pos_limit:  POS_LIMIT_DEF,
        pin_func0:  6'h00,
        pin_func1:  6'h00
    };

    typedef enum logic [2:0] {
        VSM_DW_IDLE  = 3'b001,
        VSM_DW_COUNT = 3'b010,
        VSM_DW_HELD  = 3'b100
    } vsm_dwell_state_type;

endpackage

/* File: hw/vsm_velocity_status_monitor.sv */
// velocity status monitor top: apb registers, qualifiers, alarm, pins, interrupt
// Behaviour
// - in velocity mode the reached flag rises only after speed magnitude stays above threshold for the dwell time.
// - the reached flag stays low whenever speed magnitude does not exceed the threshold; here it holds its value while ce is low.
// - a pin with code 19 is closed while reached holds, code 20 gives the inverse.
// - the dwell time takes 0 to 30000 ms and resets to 10 ms.
// - the reach threshold takes 0 to 100 rps and resets to 10 rps.
// - in velocity mode the consistent flag rises after speed error stays inside the band for the dwell time.
// - the consistent flag falls whenever actual speed leaves the band around the command; here it holds its value while ce is low.
// - a pin with code 17 is closed while consistent holds, code 18 gives the inverse.
// - the band takes 0.1 to 100 rps and resets to 0.2 rps.
// - the method setting accepts 1 or 2 and resets to 2.
// - with method 1 the position error is checked and an alarm raised when it passes the limit; here only while in velocity mode.
// - with method 2 no position check is made and no alarm is ever raised.
// - in speed-only control the loop takes its gain and integral time from two settings, 183 and 189 by default.
// - control mode value 1 selects command torque mode, commanded by the host over its link.
//
// Design decisions made here: the APB slave port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
module vsm_velocity_status_monitor
    import vsm_pkg::*;
#(
    parameter int unsigned CYCLES_PER_MS_P = CYCLES_PER_MS
)(
    // clock and reset
    input  wire logic               pclk,
    input  wire logic               presetn,
    input  wire logic               ce,
    // apb slave
    input  wire logic [11:0]        paddr,
    input  wire logic               psel,
    input  wire logic               penable,
    input  wire logic               pwrite,
    input  wire logic [31:0]        pwdata,
    output logic [31:0]             prdata,
    output logic                    pready,
    output logic                    pslverr,
    // motion feedback, speeds in 0.1 rps
    input  wire logic signed [15:0] actual_speed,
    input  wire logic signed [15:0] command_speed,
    input  wire logic signed [31:0] actual_position,
    input  wire logic signed [31:0] command_position,
    // status outputs
    output logic                    velocity_reached_flag,
    output logic                    velocity_consistent_flag,
    output logic [PIN_COUNT-1:0]    pin_closed,
    output logic                    position_error_alarm,
    output logic                    torque_mode_active,
    output logic [14:0]             speed_loop_prop_gain,
    output logic [14:0]             speed_loop_integral_time,
    output logic                    irq
);

    vsm_cfg_type        cfg_reg;
    vsm_cfg_type        cfg_next;
    logic [IRQ_W-1:0]   irq_status_reg;
    logic [IRQ_W-1:0]   irq_status_next;
    logic [IRQ_W-1:0]   irq_en_reg;
    logic [IRQ_W-1:0]   irq_en_next;
    logic [31:0]        rd_mux;
    logic               reach_q;
    logic               coin_q;

    // apb phases, one wait state on every access
    wire                apb_access = psel & penable;
    wire                apb_done   = apb_access & pready;
    wire                apb_first  = apb_access & ~pready;
    wire                wr_en      = apb_done & pwrite;

    // address decode
    wire hit_ctrl   = (paddr == ADDR_CTRL);
    wire hit_dwell  = (paddr == ADDR_DWELL);
    wire hit_reach  = (paddr == ADDR_REACH_THR);
    wire hit_band   = (paddr == ADDR_BAND);
    wire hit_prop   = (paddr == ADDR_PROP_GAIN);
    wire hit_integ  = (paddr == ADDR_INTEG_TIME);
    wire hit_limit  = (paddr == ADDR_POS_LIMIT);
    wire hit_pins   = (paddr == ADDR_PIN_FUNC);
    wire hit_stat   = (paddr == ADDR_STATUS);
    wire hit_istat  = (paddr == ADDR_IRQ_STATUS);
    wire hit_iclr   = (paddr == ADDR_IRQ_CLEAR);
    wire hit_ien    = (paddr == ADDR_IRQ_ENABLE);
    wire addr_ok    = hit_ctrl | hit_dwell | hit_reach | hit_band | hit_prop | hit_integ |
                      hit_limit | hit_pins | hit_stat | hit_istat | hit_iclr | hit_ien;

    // write fields and range checks
    wire [1:0]  wr_method = pwdata[CTRL_METHOD_LSB +: 2];
    wire        wr_mode   = pwdata[CTRL_MODE_BIT];
    wire        method_ok = (wr_method == METHOD_POS_TIME) || (wr_method == METHOD_SPEED_ONLY);
    wire        dwell_ok  = (pwdata[31:16] == 16'h0000) && (pwdata[15:0] <= DWELL_MAX);
    wire        reach_ok  = (pwdata[31:10] == 22'h000000) && (pwdata[9:0] <= REACH_MAX);
    wire        band_ok   = (pwdata[31:10] == 22'h000000) && (pwdata[9:0] >= BAND_MIN) &&
                            (pwdata[9:0] <= BAND_MAX);
    wire        gain_ok   = (pwdata[31:15] == 17'h00000) && (pwdata[14:0] <= GAIN_MAX);

    always_comb begin
        cfg_next = cfg_reg;
        if (wr_en && hit_ctrl) begin
            if (method_ok) begin
                cfg_next.method = wr_method;
            end
            cfg_next.ctrl_mode = wr_mode;
        end
        if (wr_en && hit_dwell && dwell_ok) begin
            cfg_next.dwell_ms = pwdata[15:0];
        end
        if (wr_en && hit_reach && reach_ok) begin
            cfg_next.reach_thr = pwdata[9:0];
        end
        if (wr_en && hit_band && band_ok) begin
            cfg_next.band = pwdata[9:0];
        end
        if (wr_en && hit_prop && gain_ok) begin
            cfg_next.prop_gain = pwdata[14:0];
        end
        if (wr_en && hit_integ && gain_ok) begin
            cfg_next.integ_time = pwdata[14:0];
        end
        if (wr_en && hit_limit) begin
            cfg_next.pos_limit = pwdata;
        end
        if (wr_en && hit_pins) begin
            cfg_next.pin_func0 = pwdata[5:0];
            cfg_next.pin_func1 = pwdata[PIN1_FUNC_LSB +: 6];
        end
    end

    // speed magnitude and speed error
    wire        vel_mode   = (cfg_reg.ctrl_mode == MODE_VELOCITY);
    wire [15:0] speed_abs  = actual_speed[15] ? 16'(-actual_speed) : actual_speed;
    wire [16:0] speed_err  = {actual_speed[15], actual_speed} - {command_speed[15], command_speed};
    wire [16:0] err_abs    = speed_err[16] ? 17'(-speed_err) : speed_err;
    wire        reach_cond = speed_abs > {6'h00, cfg_reg.reach_thr};
    wire        coin_cond  = err_abs <= {7'h00, cfg_reg.band};

    // position error against the alarm limit
    wire [32:0] pos_err    = {actual_position[31], actual_position} -
                             {command_position[31], command_position};
    wire [32:0] pos_abs    = pos_err[32] ? 33'(-pos_err) : pos_err;
    wire        pos_over   = pos_abs > {1'b0, cfg_reg.pos_limit};
    wire        alarm_next = vel_mode && (cfg_reg.method == METHOD_POS_TIME) && pos_over;

    vsm_dwell_timer u_reach_dwell (
        .pclk          (pclk),
        .presetn       (presetn),
        .ce            (ce),
        .cycles_per_ms (MS_CNT_W'(CYCLES_PER_MS_P)),
        .dwell_ms      (cfg_reg.dwell_ms),
        .cond          (reach_cond),
        .qualified     (reach_q)
    );

    vsm_dwell_timer u_coin_dwell (
        .pclk          (pclk),
        .presetn       (presetn),
        .ce            (ce),
        .cycles_per_ms (MS_CNT_W'(CYCLES_PER_MS_P)),
        .dwell_ms      (cfg_reg.dwell_ms),
        .cond          (coin_cond),
        .qualified     (coin_q)
    );

    // flags only in velocity mode
    wire reach_next = reach_q & vel_mode & reach_cond;
    wire coin_next  = coin_q & vel_mode & coin_cond;

    // pin function codes
    wire [PIN_COUNT*6-1:0] pin_funcs = {cfg_reg.pin_func1, cfg_reg.pin_func0};

    genvar gi;
    generate
        for (gi = 0; gi < PIN_COUNT; gi = gi + 1) begin : g_pin
            vsm_pin_driver u_pin (
                .pclk    (pclk),
                .presetn (presetn),
                .ce      (ce),
                .func    (pin_funcs[gi*6 +: 6]),
                .reach   (velocity_reached_flag),
                .coin    (velocity_consistent_flag),
                .closed  (pin_closed[gi])
            );
        end
    endgenerate

    // interrupt events, set wins over clear
    wire [IRQ_W-1:0] irq_event = {alarm_next & ~position_error_alarm,
                                  coin_next & ~velocity_consistent_flag,
                                  reach_next & ~velocity_reached_flag};
    wire [IRQ_W-1:0] irq_clear = (wr_en && hit_iclr) ? pwdata[IRQ_W-1:0] : '0;

    assign irq_status_next = (irq_status_reg & ~irq_clear) | irq_event;
    assign irq_en_next     = (wr_en && hit_ien) ? pwdata[IRQ_W-1:0] : irq_en_reg;

    // read mux
    wire [31:0] rd_ctrl  = {23'h000000, cfg_reg.ctrl_mode, 6'h00, cfg_reg.method};
    wire [31:0] rd_pins  = {18'h00000, cfg_reg.pin_func1, 2'h0, cfg_reg.pin_func0};
    wire [31:0] rd_stat  = {28'h0000000, torque_mode_active, position_error_alarm,
                            velocity_consistent_flag, velocity_reached_flag};

    always_comb begin
        rd_mux = 32'h0000_0000;
        case (1'b1)
            hit_ctrl:  rd_mux = rd_ctrl;
            hit_dwell: rd_mux = {16'h0000, cfg_reg.dwell_ms};
            hit_reach: rd_mux = {22'h000000, cfg_reg.reach_thr};
            hit_band:  rd_mux = {22'h000000, cfg_reg.band};
            hit_prop:  rd_mux = {17'h00000, cfg_reg.prop_gain};
            hit_integ: rd_mux = {17'h00000, cfg_reg.integ_time};
            hit_limit: rd_mux = cfg_reg.pos_limit;
            hit_pins:  rd_mux = rd_pins;
            hit_stat:  rd_mux = rd_stat;
            hit_istat: rd_mux = {29'h00000000, irq_status_reg};
            hit_ien:   rd_mux = {29'h00000000, irq_en_reg};
            default:   rd_mux = 32'h0000_0000;
        endcase
    end

    wire [31:0] prdata_next  = (apb_first && !pwrite) ? rd_mux : 32'h0000_0000;
    wire        pslverr_next = apb_first & ~addr_ok;
    wire        irq_next     = |(irq_status_next & irq_en_next);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cfg_reg        <= CFG_DEF;
            irq_status_reg <= '0;
            irq_en_reg     <= '0;
            pready         <= 1'b0;
            prdata         <= 32'h0000_0000;
            pslverr        <= 1'b0;
            irq            <= 1'b0;
        end else if (ce) begin
            cfg_reg        <= cfg_next;
            irq_status_reg <= irq_status_next;
            irq_en_reg     <= irq_en_next;
            pready         <= apb_first;
            prdata         <= prdata_next;
            pslverr        <= pslverr_next;
            irq            <= irq_next;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            velocity_reached_flag    <= 1'b0;
            velocity_consistent_flag <= 1'b0;
            position_error_alarm     <= 1'b0;
            torque_mode_active       <= 1'b0;
            speed_loop_prop_gain     <= PROP_DEF;
            speed_loop_integral_time <= INTEG_DEF;
        end else if (ce) begin
            velocity_reached_flag    <= reach_next;
            velocity_consistent_flag <= coin_next;
            position_error_alarm     <= alarm_next;
            torque_mode_active       <= cfg_reg.ctrl_mode == MODE_TORQUE;
            speed_loop_prop_gain     <= cfg_reg.prop_gain;
            speed_loop_integral_time <= cfg_reg.integ_time;
        end
    end

    // checks
    a_reach_low: assert property (@(posedge pclk) disable iff (!presetn)
        ce && !reach_cond |=> !velocity_reached_flag)
        else $error("reached flag high with speed at or below threshold");

    a_reach_cause: assert property (@(posedge pclk) disable iff (!presetn)
        $rose(velocity_reached_flag) |-> $past(reach_q) && $past(vel_mode))
        else $error("reached flag rose without a qualified dwell");

    a_coin_out: assert property (@(posedge pclk) disable iff (!presetn)
        ce && !coin_cond |=> !velocity_consistent_flag)
        else $error("consistent flag high with error outside band");

    a_coin_cause: assert property (@(posedge pclk) disable iff (!presetn)
        $rose(velocity_consistent_flag) |-> $past(coin_q) && $past(coin_cond))
        else $error("consistent flag rose without a qualified dwell");

    a_pin_reach: assert property (@(posedge pclk) disable iff (!presetn)
        ce && cfg_reg.pin_func0 == FUNC_REACH_OPEN
        |=> pin_closed[0] == !$past(velocity_reached_flag))
        else $error("pin 0 polarity wrong for inverted reached code");

    a_pin_coin: assert property (@(posedge pclk) disable iff (!presetn)
        ce && cfg_reg.pin_func1 == FUNC_COIN_CLOSED
        |=> pin_closed[1] == $past(velocity_consistent_flag))
        else $error("pin 1 polarity wrong for consistent code");

    a_method_legal: assert property (@(posedge pclk) disable iff (!presetn)
        cfg_reg.method == METHOD_POS_TIME || cfg_reg.method == METHOD_SPEED_ONLY)
        else $error("method setting holds an illegal value");

    a_no_alarm_m2: assert property (@(posedge pclk) disable iff (!presetn)
        ce && cfg_reg.method == METHOD_SPEED_ONLY |=> !position_error_alarm)
        else $error("position alarm raised in speed-only method");

    a_alarm_m1: assert property (@(posedge pclk) disable iff (!presetn)
        ce && vel_mode && cfg_reg.method == METHOD_POS_TIME && pos_over
        |=> position_error_alarm)
        else $error("position alarm missed with error over limit");

    a_ranges: assert property (@(posedge pclk) disable iff (!presetn)
        cfg_reg.dwell_ms <= DWELL_MAX && cfg_reg.reach_thr <= REACH_MAX &&
        cfg_reg.band >= BAND_MIN && cfg_reg.band <= BAND_MAX)
        else $error("setting outside its legal range");

    a_irq_level: assert property (@(posedge pclk) disable iff (!presetn)
        ce ##1 ce |-> irq == |(irq_status_reg & irq_en_reg))
        else $error("interrupt output disagrees with enabled status");

    c_reach_rise: cover property (@(posedge pclk) disable iff (!presetn)
        $rose(velocity_reached_flag));
    c_coin_rise: cover property (@(posedge pclk) disable iff (!presetn)
        $rose(velocity_consistent_flag));
    c_alarm: cover property (@(posedge pclk) disable iff (!presetn)
        $rose(position_error_alarm));
    c_bad_addr: cover property (@(posedge pclk) disable iff (!presetn)
        pready && pslverr);

endmodule
`default_nettype wire

/* File: testbench/testbench.sv */
// self-checking bench for the velocity status monitor
`timescale 1ns/1ps
`default_nettype none
module testbench;
    import vsm_pkg::*;
    logic               pclk, presetn, psel, penable, pwrite, pready, pslverr, e, ce;
    logic               vr, vc, al, tq, irq;
    logic        [11:0] paddr;
    logic        [31:0] pwdata, prdata, r, v;
    logic signed [15:0] act, cmd;
    logic signed [31:0] apos, cpos;
    logic         [1:0] pins, seen;
    logic        [14:0] kp, ti;
    int                 n_fail, checks, cyc;
    localparam int      CPM = 4;
    vsm_velocity_status_monitor #(.CYCLES_PER_MS_P(CPM)) dut_u (.pclk(pclk), .presetn(presetn),
        .ce(ce), .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite),
        .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .actual_speed(act), .command_speed(cmd), .actual_position(apos),
        .command_position(cpos), .velocity_reached_flag(vr), .velocity_consistent_flag(vc),
        .pin_closed(pins), .position_error_alarm(al), .torque_mode_active(tq),
        .speed_loop_prop_gain(kp), .speed_loop_integral_time(ti), .irq(irq));
    vsm_host_model host_u (.pclk(pclk), .presetn(presetn), .pin_closed(pins), .pins_seen(seen));
    task automatic wrap_up;
        if (n_fail == 0 && checks > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    task automatic chk(input logic [31:0] g, input logic [31:0] x);
        checks++;
        if (g !== x) begin
            n_fail++;
            $display("mismatch t=%0t got=%h exp=%h", $time, g, x);
        end
    endtask
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge pclk);
        {psel, penable, pwrite, paddr, pwdata} <= {1'b1, 1'b0, w, a, d};
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        r = prdata;
        e = pslverr;
        {psel, penable} <= 2'b00;
    endtask
    // condition seen one edge late, flag flop one edge, bench look one edge
    function automatic logic [31:0] rise_len(input int d_ms);
        return 32'(d_ms * CPM + 3);
    endfunction
    task automatic rise(input logic s);
        int n;
        n = 0;
        while ((s ? vc : vr) !== 1'b1 && n < 200) begin
            @(posedge pclk);
            n++;
        end
        chk(32'(n), rise_len(1));
    endtask
    initial begin
        pclk = 1'b0;
        forever #4 pclk = ~pclk;
    end
    always @(posedge pclk) begin
        cyc++;
        if (cyc == 20000) begin
            n_fail++;
            wrap_up();
        end
    end
    initial begin
        {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
        {act, cmd, apos, cpos} = '0;
        ce = 1'b1;
        r = $urandom(32'hD08CEB82);
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        chk({kp, ti}, {15'h00B7, 15'h00BD});
        apb(0, ADDR_DWELL, 0);
        chk(r, 32'hA);
        apb(0, ADDR_REACH_THR, 0);
        chk(r, 32'h64);
        apb(0, ADDR_BAND, 0);
        chk(r, 32'h2);
        apb(0, ADDR_CTRL, 0);
        chk(r[1:0], 32'h2);
        apb(0, 12'h030, 0);
        chk(e, 32'h1);
        apb(1, ADDR_DWELL, 30001 + $urandom % 500);
        apb(0, ADDR_DWELL, 0);
        chk(r, 32'hA);
        apb(1, ADDR_DWELL, 1);
        apb(0, ADDR_DWELL, 0);
        chk(r, 32'h1);
        v = $urandom % 30001;
        apb(1, ADDR_PROP_GAIN, v);
        repeat (2) @(posedge pclk);
        chk(kp, v);
        apb(1, ADDR_PIN_FUNC, 32'h1113);
        apb(1, ADDR_IRQ_ENABLE, 32'h1);
        act <= 16'(101 + $urandom % 800);
        rise(0);
        repeat (4) @(posedge pclk);
        chk({seen, irq}, 32'h3);
        apb(1, ADDR_IRQ_CLEAR, 32'h7);
        repeat (2) @(posedge pclk);
        chk(irq, 32'h0);
        {ce, act} <= {1'b0, 16'sd100};
        repeat (4) @(posedge pclk);
        chk(vr, 32'h1);
        ce <= 1'b1;
        repeat (4) @(posedge pclk);
        chk({vr, seen}, 32'h0);
        act <= 16'sd200;
        repeat (4) @(posedge pclk);
        act <= -16'sd5;
        @(posedge pclk);
        act <= -16'sd200;
        rise(0);
        cmd <= -16'sd199;
        rise(1);
        apb(0, ADDR_STATUS, 0);
        chk(r, 32'h3);
        apb(0, ADDR_IRQ_STATUS, 0);
        chk(r, 32'h3);
        apb(1, ADDR_PIN_FUNC, 32'h1214);
        repeat (4) @(posedge pclk);
        chk(seen, 32'h0);
        cmd <= -16'sd197;
        repeat (4) @(posedge pclk);
        chk({vc, seen}, 32'h2);
        apb(1, ADDR_POS_LIMIT, 100);
        apb(1, ADDR_CTRL, 1);
        cpos <= 101;
        repeat (3) @(posedge pclk);
        chk(al, 32'h1);
        cpos <= 100;
        repeat (3) @(posedge pclk);
        chk(al, 32'h0);
        apb(1, ADDR_CTRL, 2);
        cpos <= 5000;
        repeat (3) @(posedge pclk);
        chk(al, 32'h0);
        apb(1, ADDR_CTRL, 32'h103);
        repeat (3) @(posedge pclk);
        chk({tq, vr}, 32'h2);
        apb(0, ADDR_CTRL, 0);
        chk(r, 32'h102);
        wrap_up();
    end
endmodule
`default_nettype wire

/* File: testbench/vsm_host_model.sv */
// host model: samples the drive's digital output contacts each cycle
`timescale 1ns/1ps
`default_nettype none
module vsm_host_model (
    // clock and reset
    input  wire logic       pclk,
    input  wire logic       presetn,
    // contacts from the drive
    input  wire logic [1:0] pin_closed,
    output logic      [1:0] pins_seen
);
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pins_seen <= 2'h0;
        end else begin
            pins_seen <= pin_closed;
        end
    end
endmodule
`default_nettype wire
